// ===== logic/cep_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the cell error perf_monitor counter bank
// ----------------------------------------------------------------------------
package cep_pkg;

    // Bus geometry
    localparam int CEP_ADDR_W = 12;          // Byte address width of the slave
    localparam int CEP_IDX_W = 10;           // Word index width (address / 4)
    localparam int CEP_CNT_W = 16;           // Width of each counter

    // Counter slots
    localparam int CEP_NUM_CNT = 3;          // Counters in the bank
    localparam int CEP_CNT_HEC = 0;          // Multi-bit header check errors
    localparam int CEP_CNT_SHR = 1;          // Shared idle cell / PRBS errors
    localparam int CEP_CNT_VLD = 2;          // Valid cells received

    // Register indices; byte address is four times the index
    localparam logic [9:0] CEP_IDX_HEC_HI = 10'h030;
    localparam logic [9:0] CEP_IDX_HEC_LO = 10'h031;
    localparam logic [9:0] CEP_IDX_SHR_HI = 10'h032;
    localparam logic [9:0] CEP_IDX_SHR_LO = 10'h033;
    localparam logic [9:0] CEP_IDX_VLD_HI = 10'h034;
    localparam logic [9:0] CEP_IDX_VLD_LO = 10'h035;
    localparam logic [9:0] CEP_IDX_CTRL = 10'h040;
    localparam logic [9:0] CEP_IDX_STAT = 10'h041;
    localparam logic [9:0] CEP_IDX_MASK = 10'h042;

    // Index tables per counter slot, in slot order
    localparam logic [9:0] CEP_HI_IDX [CEP_NUM_CNT] = '{CEP_IDX_HEC_HI, CEP_IDX_SHR_HI, CEP_IDX_VLD_HI};
    localparam logic [9:0] CEP_LO_IDX [CEP_NUM_CNT] = '{CEP_IDX_HEC_LO, CEP_IDX_SHR_LO, CEP_IDX_VLD_LO};

    // Field positions and reset values
    localparam int CEP_CTRL_ATM_BIT = 0;     // 1 = ATM UNI, 0 = clear channel
    localparam logic CEP_CTRL_ATM_RST = 1'b1;
    localparam logic [15:0] CEP_CNT_RST = 16'h0000;
    localparam logic [2:0] CEP_STAT_RST = 3'h0;
    localparam logic [2:0] CEP_MASK_RST = 3'h0;

    // AXI4-Lite response codes
    localparam logic [1:0] CEP_RESP_OKAY = 2'h0;
    localparam logic [1:0] CEP_RESP_SLVERR = 2'h2;

endpackage

// ===== logic/cep_counter.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// One saturating counter, each byte cleared on its own read
// ----------------------------------------------------------------------------
module cep_counter
    import cep_pkg::*;
#(
    parameter int CNT_W = CEP_CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Event and byte clears
    input wire logic evt,
    input wire logic clr_hi,
    input wire logic clr_lo,
    // Count and full-scale event
    output logic [CNT_W-1:0] count,
    output logic full_hit
);

    logic [CNT_W-1:0] count_r;    // Running count
    logic [CNT_W-1:0] count_nxt;  // Next count
    logic [CNT_W-1:0] keep_mask;  // Bits surviving this cycle's clear

    // ------------------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------------------
    // The clear applies first and the event adds on top, so an event in the
    // read cycle survives, added as one to whatever the clear leaves.
    always_comb begin
        keep_mask = {{(CNT_W/2){~clr_hi}}, {(CNT_W/2){~clr_lo}}};
        count_nxt = count_r & keep_mask;
        // Full scale with no clear holds instead of wrapping
        if (evt && !((&count_r) && !clr_hi && !clr_lo)) begin
            count_nxt = count_nxt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        full_hit = (&count_nxt) && !(&count_r);
    end

    // Register the count
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_r <= CEP_CNT_RST[CNT_W-1:0];
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

endmodule

// ===== logic/cep_perf_monitor.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module cep_perf_monitor
    import cep_pkg::*;
#(
    parameter int CNT_W = CEP_CNT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Event strobes from receive cell processor and PRBS receiver
    input wire logic rx_hec_multi_err_evt,
    input wire logic rx_valid_cell_evt,
    input wire logic rx_idle_cell_evt,
    input wire logic prbs_bit_err_evt,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [CEP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [CEP_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------------------
    // True when the word index picks the high (hi=1) or low byte of slot n
    function automatic logic cnt_sel(input logic [9:0] idx, input int n, input logic hi);
        cnt_sel = hi ? (idx == CEP_HI_IDX[n]) : (idx == CEP_LO_IDX[n]);
    endfunction

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [9:0] rd_idx;                      // Word index of read request
    logic [9:0] wr_idx;                      // Word index of held write
    logic rd_take;                           // Read address handshake
    logic wr_fire;                           // Held write performed
    logic [CNT_W-1:0] cnt_w [CEP_NUM_CNT];   // Counter values
    logic [CEP_NUM_CNT-1:0] evt_w;           // Gated counter events
    logic [CEP_NUM_CNT-1:0] clr_hi_w;        // High byte clears
    logic [CEP_NUM_CNT-1:0] clr_lo_w;        // Low byte clears
    logic [CEP_NUM_CNT-1:0] full_w;          // Reached full scale

    // Write channel state
    logic awready_r, awready_nxt;            // Address slot free
    logic wready_r, wready_nxt;              // Data slot free
    logic [CEP_ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;

    // Read channel state
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // Software visible control and interrupt state
    logic ctrl_atm_r, ctrl_atm_nxt;          // Operating mode
    logic [CEP_NUM_CNT-1:0] stat_r, stat_nxt; // Sticky full-scale flags
    logic [CEP_NUM_CNT-1:0] mask_r, mask_nxt; // Interrupt enables
    logic irq_r, irq_nxt;

    assign rd_idx = s_axi_araddr[CEP_ADDR_W-1:2];
    assign wr_idx = awaddr_r[CEP_ADDR_W-1:2];
    assign rd_take = s_axi_arvalid && arready_r;
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;

    // ------------------------------------------------------------------------
    // Event steering
    // ------------------------------------------------------------------------
    // Outside ATM the header and valid counters freeze rather than clear,
    // so a mode switch keeps what was counted until software reads it.
    always_comb begin
        evt_w[CEP_CNT_HEC] = ctrl_atm_r && rx_hec_multi_err_evt;
        evt_w[CEP_CNT_VLD] = ctrl_atm_r && rx_valid_cell_evt;
        // Shared pair follows the mode
        if (ctrl_atm_r) begin
            evt_w[CEP_CNT_SHR] = rx_idle_cell_evt;
        end else begin
            evt_w[CEP_CNT_SHR] = prbs_bit_err_evt;
        end
    end

    // ------------------------------------------------------------------------
    // Counter bank
    // ------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < CEP_NUM_CNT; i++) begin : g_cnt
            // Clear strobes come from the read handshake itself
            assign clr_hi_w[i] = rd_take && cnt_sel(rd_idx, i, 1'b1);
            assign clr_lo_w[i] = rd_take && cnt_sel(rd_idx, i, 1'b0);
            // Saturating counter; a same-cycle clear applies first and the event adds on top
            cep_counter #(
                .CNT_W(CNT_W)
            ) u_cnt (
                .clock(clock),
                .reset(reset),
                .evt(evt_w[i]),
                .clr_hi(clr_hi_w[i]),
                .clr_lo(clr_lo_w[i]),
                .count(cnt_w[i]),
                .full_hit(full_w[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order; the write is done once
    // both are held, and both slots reopen when the response is taken.
    always_comb begin
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ctrl_atm_nxt = ctrl_atm_r;
        mask_nxt = mask_r;
        // Capture address
        if (s_axi_awvalid && awready_r) begin
            awaddr_nxt = s_axi_awaddr;
            awready_nxt = 1'b0;
        end
        // Capture data
        if (s_axi_wvalid && wready_r) begin
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
            wready_nxt = 1'b0;
        end
        // Perform the held write
        if (wr_fire) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = CEP_RESP_OKAY;
            if (wr_idx == CEP_IDX_CTRL) begin
                if (wstrb_r[0]) begin
                    ctrl_atm_nxt = wdata_r[CEP_CTRL_ATM_BIT];
                end
            end else if (wr_idx == CEP_IDX_MASK) begin
                if (wstrb_r[0]) begin
                    mask_nxt = wdata_r[CEP_NUM_CNT-1:0];
                end
            end else if (wr_idx >= CEP_IDX_HEC_HI && wr_idx <= CEP_IDX_VLD_LO) begin
                bresp_nxt = CEP_RESP_OKAY;   // Counters ignore writes
            end else if (wr_idx == CEP_IDX_STAT) begin
                bresp_nxt = CEP_RESP_OKAY;   // Status clears only on read
            end else begin
                bresp_nxt = CEP_RESP_SLVERR; // Unmapped
            end
        end
        // Response taken
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    // Data are sampled at the address handshake, the same edge that clears
    // the byte, so no count slips between the value shown and the clear.
    always_comb begin
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_take) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = CEP_RESP_SLVERR;
            // Counter bytes
            for (int i = 0; i < CEP_NUM_CNT; i++) begin
                if (cnt_sel(rd_idx, i, 1'b1)) begin
                    rdata_nxt[7:0] = cnt_w[i][CNT_W-1:CNT_W/2];
                    rresp_nxt = CEP_RESP_OKAY;
                end
                if (cnt_sel(rd_idx, i, 1'b0)) begin
                    rdata_nxt[7:0] = cnt_w[i][CNT_W/2-1:0];
                    rresp_nxt = CEP_RESP_OKAY;
                end
            end
            // Own registers
            if (rd_idx == CEP_IDX_CTRL) begin
                rdata_nxt[CEP_CTRL_ATM_BIT] = ctrl_atm_r;
                rresp_nxt = CEP_RESP_OKAY;
            end else if (rd_idx == CEP_IDX_STAT) begin
                rdata_nxt[CEP_NUM_CNT-1:0] = stat_r;
                rresp_nxt = CEP_RESP_OKAY;
            end else if (rd_idx == CEP_IDX_MASK) begin
                rdata_nxt[CEP_NUM_CNT-1:0] = mask_r;
                rresp_nxt = CEP_RESP_OKAY;
            end
        end
        // Data taken
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    // A counter reaching full scale sets its flag; a read of the status
    // register clears it, but a flag set in that same cycle survives.
    always_comb begin
        stat_nxt = stat_r;
        if (rd_take && rd_idx == CEP_IDX_STAT) begin
            stat_nxt = CEP_STAT_RST;
        end
        stat_nxt = stat_nxt | full_w;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= CEP_RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= CEP_RESP_OKAY;
            ctrl_atm_r <= CEP_CTRL_ATM_RST;
            stat_r <= CEP_STAT_RST;
            mask_r <= CEP_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            ctrl_atm_r <= ctrl_atm_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // High byte read returns bits 15:8 of the header error count
    a_hec_hi_read: assert property (@(posedge clock) disable iff (reset)
        (rd_take && rd_idx == CEP_IDX_HEC_HI)
        |=> (s_axi_rvalid && s_axi_rdata[7:0] == $past(cnt_w[CEP_CNT_HEC][15:8])))
        else $error("header error high byte read wrong");

    // Read of a byte leaves it zero when no event carries in
    a_read_clears: assert property (@(posedge clock) disable iff (reset)
        (rd_take && rd_idx == CEP_IDX_HEC_HI && !evt_w[CEP_CNT_HEC])
        |=> (cnt_w[CEP_CNT_HEC][15:8] == 8'h00))
        else $error("high byte not cleared by read");

    // Outside ATM the header error count never rises
    a_mode_gate: assert property (@(posedge clock) disable iff (reset)
        (!ctrl_atm_r) |=> (cnt_w[CEP_CNT_HEC] <= $past(cnt_w[CEP_CNT_HEC])))
        else $error("header counter moved outside ATM");

    // ATM idle cell advances the shared count by one
    a_idle_count: assert property (@(posedge clock) disable iff (reset)
        (ctrl_atm_r && rx_idle_cell_evt && !rd_take && cnt_w[CEP_CNT_SHR] != 16'hffff)
        |=> (cnt_w[CEP_CNT_SHR] == $past(cnt_w[CEP_CNT_SHR]) + 16'h0001))
        else $error("idle cell not counted");

    // Clear channel PRBS error advances the shared count by one
    a_prbs_count: assert property (@(posedge clock) disable iff (reset)
        (!ctrl_atm_r && prbs_bit_err_evt && !rd_take && cnt_w[CEP_CNT_SHR] != 16'hffff)
        |=> (cnt_w[CEP_CNT_SHR] == $past(cnt_w[CEP_CNT_SHR]) + 16'h0001))
        else $error("PRBS error not counted");

    // Valid cell high byte read
    a_vld_hi_read: assert property (@(posedge clock) disable iff (reset)
        (rd_take && rd_idx == CEP_IDX_VLD_HI)
        |=> (s_axi_rdata[7:0] == $past(cnt_w[CEP_CNT_VLD][15:8]) && s_axi_rresp == CEP_RESP_OKAY))
        else $error("valid cell high byte read wrong");

    // Valid cell low byte read
    a_vld_lo_read: assert property (@(posedge clock) disable iff (reset)
        (rd_take && rd_idx == CEP_IDX_VLD_LO)
        |=> (s_axi_rdata[7:0] == $past(cnt_w[CEP_CNT_VLD][7:0])))
        else $error("valid cell low byte read wrong");

    // Event in the clearing cycle leaves a count of one
    a_evt_kept: assert property (@(posedge clock) disable iff (reset)
        (rd_take && rd_idx == CEP_IDX_VLD_LO && evt_w[CEP_CNT_VLD] && cnt_w[CEP_CNT_VLD][15:8] == 8'h00)
        |=> (cnt_w[CEP_CNT_VLD] == 16'h0001))
        else $error("event lost at clear");

    // Full scale holds without a clear
    a_sat_hold: assert property (@(posedge clock) disable iff (reset)
        ((&cnt_w[CEP_CNT_VLD]) && !rd_take) |=> (&cnt_w[CEP_CNT_VLD]))
        else $error("counter wrapped past full scale");

    // Interrupt follows masked status in the same cycle
    a_irq_level: assert property (@(posedge clock) disable iff (reset)
        (|(stat_r & mask_r)) |-> irq)
        else $error("interrupt low with masked flag set");

endmodule

// ===== testbench/cep_perf_monitor_tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench for the perf_monitor counter bank
// ----------------------------------------------------------------------------
module cep_perf_monitor_tb
    import cep_pkg::*;
;
    logic clock, reset;
    logic [3:0] evt;                 // Bit 0 hec, 1 valid, 2 idle, 3 prbs
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [CEP_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    int seed = 19;                   // Fixed seed keeps runs repeatable
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int cnt [CEP_NUM_CNT];           // Reference counts per slot
    bit atm = 1'b1;                  // Reference mode, ATM after reset

    cep_perf_monitor i_cep_perf_monitor (
        .clock(clock), .reset(reset),
        .rx_hec_multi_err_evt(evt[0]), .rx_valid_cell_evt(evt[1]),
        .rx_idle_cell_evt(evt[2]), .prbs_bit_err_evt(evt[3]),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .irq(irq)
    );

    // ------------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Saturation run alone needs some 65.5k cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // Reference model and compare
    // ------------------------------------------------------------------------
    // Counters hold at full scale
    function automatic int sat(input int v);
        return (v == 'hffff) ? v : v + 1;
    endfunction

    // Mode decides which strobes count
    function automatic void note_evt(input logic [3:0] e);
        if (atm && e[0]) cnt[CEP_CNT_HEC] = sat(cnt[CEP_CNT_HEC]);
        if (atm && e[1]) cnt[CEP_CNT_VLD] = sat(cnt[CEP_CNT_VLD]);
        if (atm ? e[2] : e[3]) cnt[CEP_CNT_SHR] = sat(cnt[CEP_CNT_SHR]);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------------------
    // Dense mode fires every enabled strobe each cycle
    task automatic burst(input int n, input logic [3:0] en, input bit dense);
        logic [3:0] e;
        repeat (n) begin
            @(posedge clock);
            e = dense ? en : 4'($random(seed)) & en;
            evt <= e;
            note_evt(e);
        end
        @(posedge clock);
        evt <= 4'h0;
    endtask

    // One write; valids go up at once and each drops when its channel is taken
    task automatic wr(input logic [9:0] idx, input logic [31:0] dat, input logic [1:0] exp);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= {idx, 2'b00};
        wvalid <= 1'b1;
        wdata <= dat;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clock);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, exp});
    endtask

    // One read; ev strobes land on the edge that takes the address
    task automatic rd(input logic [9:0] idx, input logic [3:0] ev, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= {idx, 2'b00};
        rready <= 1'b1;
        evt <= ev;
        do begin
            @(posedge clock);
            evt <= 4'h0;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        dat = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Read one counter byte, compare, then clear that byte in the model
    task automatic rd_cnt(input int s, input bit hi, input logic [3:0] ev);
        logic [31:0] exp;
        exp = 32'(hi ? (cnt[s] >> 8) : (cnt[s] & 'hff));
        rd(hi ? CEP_HI_IDX[s] : CEP_LO_IDX[s], ev, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, CEP_RESP_OKAY});
        cnt[s] = cnt[s] & (hi ? 'h00ff : 'hff00);
        note_evt(ev);
    endtask

    task automatic rd_all();
        for (int s = 0; s < CEP_NUM_CNT; s++) begin
            rd_cnt(s, 1'b1, 4'h0);
            rd_cnt(s, 1'b0, 4'h0);
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        evt = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        for (int s = 0; s < CEP_NUM_CNT; s++) cnt[s] = 0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        // Reset values, control word and an unmapped place
        rd_all();
        rd(CEP_IDX_CTRL, 4'h0, d, r);
        check(d, 32'h1);
        rd(10'h3ff, 4'h0, d, r);
        check({r, d[29:0]}, {CEP_RESP_SLVERR, 30'h0});
        wr(10'h3ff, 32'h1, CEP_RESP_SLVERR);
        // Random traffic in ATM mode, reads twice to see the clear
        for (int i = 0; i < 4; i++) begin
            burst(1 + ($unsigned($random(seed)) % 700), 4'hf, 1'b0);
            rd_all();
            rd_all();
        end
        // Strobe on the clearing edge survives, added to what the read leaves
        burst(20, 4'h5, 1'b1);
        rd_cnt(CEP_CNT_HEC, 1'b0, 4'h1);
        rd_cnt(CEP_CNT_SHR, 1'b1, 4'h4);
        rd_cnt(CEP_CNT_VLD, 1'b0, 4'h2);
        rd_all();
        // Writes to a counter are ignored
        burst(5, 4'h4, 1'b1);
        wr(CEP_IDX_SHR_LO, 32'hff, CEP_RESP_OKAY);
        rd_all();
        // Clear channel: cell counters freeze, shared counts PRBS errors
        burst(30, 4'hf, 1'b0);
        wr(CEP_IDX_CTRL, 32'h0, CEP_RESP_OKAY);
        atm = 1'b0;
        burst(400, 4'hf, 1'b0);
        rd_all();
        wr(CEP_IDX_CTRL, 32'h1, CEP_RESP_OKAY);
        atm = 1'b1;
        // Saturation of two counters; status masked, unmasked, read-cleared
        burst(65540, 4'h3, 1'b1);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        wr(CEP_IDX_MASK, 32'h1, CEP_RESP_OKAY);
        rd(CEP_IDX_MASK, 4'h0, d, r);
        check(d, 32'h1);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        rd(CEP_IDX_STAT, 4'h0, d, r);
        check(d, 32'((1 << CEP_CNT_HEC) | (1 << CEP_CNT_VLD)));
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        rd_all();
        end_of_test();
    end
endmodule
